// >>> rtl/startup_map.svh
// constants for the terminal startup sequencer: switch positions and timing
`ifndef STARTUP_MAP_SVH
`define STARTUP_MAP_SVH
// positions of the eight-way mode switch (bit index, position n is bit n-1)
`define SW_MODE_SELECT_POSITION 0
`define SW_DEMO_SELECT_POSITION 2
`define SW_FLASH_ERASE_POSITION 3
`define SW_WIDTH 8
// timing: clock period in ns and startup screen hold in ms
`define CLK_PERIOD_NS 5
`define STARTUP_HOLD_MS 5000
// cycles of the led phase (short lamp test)
`define LED_PHASE_CYCLES 16'h0010
`endif

// >>> rtl/startup_pkg.sv
// types shared by the terminal startup sequencer
package startup_pkg;
    // top-level startup sequence states
    typedef enum logic [3:0] {
        ST_LED_TEST,
        ST_SELF_TEST,
        ST_KEY_TEST,
        ST_KEY_RELEASE,
        ST_SORT_MSGS,
        ST_NO_DESCRIPTION,
        ST_STARTUP_SCREEN,
        ST_SETUP_SCREEN,
        ST_MAIN_SCREEN
    } seq_state_type;
    // screen currently presented
    typedef enum logic [2:0] {
        SCR_NONE,
        SCR_DOWNLOAD,
        SCR_RELEASE_KEYS,
        SCR_INIT_BUFFER,
        SCR_STARTUP,
        SCR_SETUP,
        SCR_MAIN
    } screen_type;
endpackage : startup_pkg

// >>> rtl/hold_timer.sv
// down-counter that signals when a programmed interval has elapsed
`timescale 1ns/1ps
module hold_timer #(
    parameter int WIDTH = 32
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_cycles,
    output logic o_done
);
    logic [WIDTH-1:0] count;
    logic running;

    // ============================================================
    // counting
    // load on start, count to one, pulse done on the last cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            running <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                count <= i_cycles;
                running <= 1'b1;
            end else if (running) begin
                if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule : hold_timer

// >>> rtl/key_encoder.sv
// transparent-mode key encoder: press and release codes as ascii characters
`timescale 1ns/1ps
module key_encoder #(
    parameter int NUM_KEYS = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic [NUM_KEYS-1:0] i_keys,
    input wire logic i_tx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_char
);
    logic [NUM_KEYS-1:0] sent;
    logic [NUM_KEYS-1:0] diff;
    logic found;
    logic [7:0] code;
    logic [NUM_KEYS-1:0] flip;

    // ascii code: 'A'+key for press, 'a'+key for release
    function automatic logic [7:0] key_code(input int idx, input logic pr);
        key_code = pr ? 8'(8'h41 + idx) : 8'(8'h61 + idx);
    endfunction : key_code

    assign diff = i_enable ? (i_keys ^ sent) : '0;

    // pick the lowest changed key
    always_comb begin
        found = 1'b0;
        code = 8'h00;
        flip = '0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            if (!found && diff[k]) begin
                found = 1'b1;
                code = key_code(k, i_keys[k]);
                flip[k] = 1'b1;
            end
        end
    end

    // ============================================================
    // one character per key edge, held until the link takes it
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sent <= '0;
            o_tx_valid <= 1'b0;
            o_tx_char <= 8'h00;
        end else if (!i_enable) begin
            sent <= '0;
            o_tx_valid <= 1'b0;
        end else if (o_tx_valid && !i_tx_ready) begin
            o_tx_valid <= 1'b1;
        end else if (found) begin
            o_tx_valid <= 1'b1; // [R12]
            o_tx_char <= code;
            sent <= sent ^ flip;
        end else begin
            o_tx_valid <= 1'b0;
        end
    end
endmodule : key_encoder

// >>> rtl/terminal_startup_mode_select.sv
// power-up sequencer and operating mode selection for the operator terminal
// ============================================================
// Overview of operation
// (R1) mode switch sampled at power-up; chosen mode holds from then on
// (R2) position one on gives standard mode, off gives transparent mode
// (R3) position three selects demo, position four erases flash; others unused
// (R4) all leds driven on as the first startup step
// (R5) after leds, self-test checks and initialises modules, may report
// (R6) valid description found: present the startup screen
// (R7) startup screen held five seconds, then main screen
// (R8) enter during startup screen leads to setup screen instead
// (R9) enter held before startup screen flags a keyboard-test error
// (R10) held key shows release request, cleared once all keys released
// (R11) stored messages sorted at power-up with buffer-initialising indication
// (R12) transparent mode sends distinct press and release ascii codes
// (R13) host drives display and key leds by escape sequences; no host input here, o_leds follow the led phase only
// (R14) standard mode decodes keys and selects screens internally
// (R15) without valid description: no controller link, no keyboard input
// (R16) switch sampled once per power-up; later changes ignored
`timescale 1ns/1ps
`include "startup_map.svh"
module terminal_startup_mode_select
    import startup_pkg::*;
#(
    parameter int NUM_KEYS = 16,
    parameter int NUM_LEDS = 16,
    parameter int ENTER_KEY = 0,
    parameter int HOLD_CYCLES =
        `STARTUP_HOLD_MS * (1000000 / `CLK_PERIOD_NS)
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [`SW_WIDTH-1:0] i_mode_switch,
    input wire logic [NUM_KEYS-1:0] i_keys,
    input wire logic i_self_test_done,
    input wire logic i_self_test_fail,
    input wire logic i_description_valid,
    input wire logic i_sort_done,
    input wire logic i_tx_ready,
    output logic [NUM_LEDS-1:0] o_leds,
    output logic o_self_test_start,
    output logic o_sort_start,
    output logic o_flash_erase,
    output logic o_standard_mode,
    output logic o_demo_mode,
    output logic o_link_enable,
    output logic o_keyboard_enable,
    output logic o_key_test_error,
    output logic o_self_test_error,
    output screen_type o_screen,
    output logic o_tx_valid,
    output logic [7:0] o_tx_char
);
    seq_state_type state;
    seq_state_type next_state;
    logic sampled;
    logic [15:0] led_count;
    logic hold_start;
    logic hold_done;
    logic enter_pressed;
    logic any_key;
    logic transparent_active;
    logic enc_valid;
    logic [7:0] enc_char;

    assign enter_pressed = i_keys[ENTER_KEY];
    assign any_key = |i_keys;

    // ============================================================
    // mode switch capture
    // taken by a clocked process on the first edge after reset release
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sampled <= 1'b0;
            o_standard_mode <= 1'b1;
            o_demo_mode <= 1'b0;
            o_flash_erase <= 1'b0;
        end else if (!sampled) begin
            sampled <= 1'b1; // [R16]
            o_standard_mode <=
                i_mode_switch[`SW_MODE_SELECT_POSITION]; // [R1] [R2]
            o_demo_mode <=
                i_mode_switch[`SW_DEMO_SELECT_POSITION]; // [R3]
            o_flash_erase <=
                i_mode_switch[`SW_FLASH_ERASE_POSITION]; // [R3]
        end else begin
            o_flash_erase <= 1'b0; // erase request is a single pulse
        end
    end

    // ============================================================
    // led phase length counter
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            led_count <= 16'h0000;
        end else if (state == ST_LED_TEST && sampled) begin
            led_count <= led_count + 16'h0001;
        end
    end

    // ============================================================
    // sequence next-state logic
    always_comb begin
        next_state = state;
        hold_start = 1'b0;
        unique case (state)
            ST_LED_TEST: begin
                if (sampled && led_count == `LED_PHASE_CYCLES - 16'h0001) begin
                    next_state = ST_SELF_TEST; // [R5]
                end
            end
            ST_SELF_TEST: begin
                if (i_self_test_done) begin
                    next_state = ST_KEY_TEST;
                end
            end
            ST_KEY_TEST: begin
                if (!i_description_valid) begin
                    next_state = ST_NO_DESCRIPTION; // [R15]
                end else if (any_key) begin
                    next_state = ST_KEY_RELEASE; // [R10]
                end else begin
                    next_state = ST_SORT_MSGS; // [R11]
                end
            end
            ST_KEY_RELEASE: begin
                if (!any_key) begin
                    next_state = ST_SORT_MSGS; // [R10]
                end
            end
            ST_SORT_MSGS: begin
                if (i_sort_done) begin
                    next_state = ST_STARTUP_SCREEN; // [R6]
                    hold_start = 1'b1;
                end
            end
            ST_NO_DESCRIPTION: begin
                if (i_description_valid) begin
                    next_state = ST_KEY_TEST; // [R15]
                end
            end
            ST_STARTUP_SCREEN: begin
                if (enter_pressed) begin
                    next_state = ST_SETUP_SCREEN; // [R8]
                end else if (hold_done) begin
                    next_state = ST_MAIN_SCREEN; // [R7]
                end
            end
            ST_SETUP_SCREEN: begin
                next_state = ST_SETUP_SCREEN;
            end
            ST_MAIN_SCREEN: begin
                next_state = ST_MAIN_SCREEN;
            end
        endcase
    end

    // ============================================================
    // state register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_LED_TEST;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // startup screen hold timer
    hold_timer #(
        .WIDTH(32)
    ) u_hold (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_start(hold_start),
        .i_cycles(32'(HOLD_CYCLES)),
        .o_done(hold_done)
    );

    // ============================================================
    // lamps and test strobes
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_leds <= '1;
            o_self_test_start <= 1'b0;
            o_sort_start <= 1'b0;
        end else begin
            o_leds <= (next_state == ST_LED_TEST) ? '1 : '0; // [R4]
            o_self_test_start <= (state == ST_LED_TEST) &&
                (next_state == ST_SELF_TEST); // [R5]
            o_sort_start <= (state != ST_SORT_MSGS) &&
                (next_state == ST_SORT_MSGS); // [R11]
        end
    end

    // ============================================================
    // error flags: sticky until the next power-up
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_key_test_error <= 1'b0;
            o_self_test_error <= 1'b0;
        end else begin
            if (state == ST_KEY_TEST && i_description_valid && any_key) begin
                o_key_test_error <= 1'b1; // [R9] [R10]
            end
            if (state == ST_SELF_TEST && i_self_test_done &&
                i_self_test_fail) begin
                o_self_test_error <= 1'b1; // [R5]
            end
        end
    end

    // ============================================================
    // screen selection
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_screen <= SCR_NONE;
        end else begin
            unique case (next_state)
                ST_NO_DESCRIPTION: o_screen <= SCR_DOWNLOAD;
                ST_KEY_RELEASE: o_screen <= SCR_RELEASE_KEYS; // [R10]
                ST_SORT_MSGS: o_screen <= SCR_INIT_BUFFER; // [R11]
                ST_STARTUP_SCREEN: o_screen <= SCR_STARTUP; // [R6]
                ST_SETUP_SCREEN: o_screen <= SCR_SETUP; // [R8]
                ST_MAIN_SCREEN: o_screen <= SCR_MAIN; // [R7] [R14]
                default: o_screen <= SCR_NONE;
            endcase
        end
    end

    // ============================================================
    // link and keyboard gating
    // active only after startup, and with a valid description
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_link_enable <= 1'b0;
            o_keyboard_enable <= 1'b0;
        end else begin
            o_keyboard_enable <= i_description_valid &&
                (next_state == ST_MAIN_SCREEN ||
                 next_state == ST_SETUP_SCREEN); // [R15]
            o_link_enable <= i_description_valid && !o_demo_mode &&
                next_state == ST_MAIN_SCREEN; // [R3] [R15]
        end
    end

    // transparent encoding only once the link is up [R13]
    assign transparent_active = o_link_enable && o_keyboard_enable &&
        !o_standard_mode;

    // ============================================================
    // transparent-mode key codes
    key_encoder #(
        .NUM_KEYS(NUM_KEYS)
    ) u_enc (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_enable(transparent_active),
        .i_keys(i_keys),
        .i_tx_ready(i_tx_ready),
        .o_tx_valid(enc_valid),
        .o_tx_char(enc_char)
    );

    // encoder outputs are already registered; in standard mode nothing
    // leaves, key decoding stays inside the terminal
    assign o_tx_valid = enc_valid; // [R12] [R14]
    assign o_tx_char = enc_char;
endmodule : terminal_startup_mode_select

// >>> dv/plc_link_model.sv
// serial controller model that takes characters from the terminal
`timescale 1ns/1ps
module plc_link_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_char,
    output logic o_tx_ready
);
    int seed = 32'h9364;
    logic [7:0] got[$];
    // record a character when valid and ready meet at an edge
    always @(posedge i_mclk) begin
        if (!i_rst && i_tx_valid === 1'b1 && o_tx_ready) got.push_back(i_tx_char);
    end
    // ready stalls at random in slow mode; only listens, sends no commands
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) o_tx_ready <= 1'b0;
        else o_tx_ready <= !i_slow || ($random(seed) % 3 == 0);
    end
endmodule : plc_link_model

// >>> dv/startup_properties.sv
// assertions on the ports of the terminal startup sequencer
`timescale 1ns/1ps
`include "startup_map.svh"
module startup_properties
    import startup_pkg::*;
#(
    parameter int NUM_KEYS = 16,
    parameter int NUM_LEDS = 16,
    parameter int ENTER_KEY = 0,
    parameter int HOLD_CYCLES = 100
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [NUM_KEYS-1:0] i_keys,
    input wire logic i_sort_done,
    input wire logic i_tx_ready,
    input wire logic [NUM_LEDS-1:0] o_leds,
    input wire logic o_self_test_start,
    input wire logic o_sort_start,
    input wire logic o_standard_mode,
    input wire logic o_demo_mode,
    input wire logic o_link_enable,
    input wire logic o_keyboard_enable,
    input wire logic o_key_test_error,
    input wire screen_type o_screen,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_char
);
    logic captured;
    int hold_cnt;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // marks edges after the first one following reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) captured <= 1'b0;
        else captured <= 1'b1;
    end
    // counts cycles spent on the startup screen
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) hold_cnt <= 0;
        else hold_cnt <= (o_screen == SCR_STARTUP) ? hold_cnt + 1 : 0;
    end
    sequence sort_seen;
        o_screen == SCR_INIT_BUFFER && i_sort_done;
    endsequence
    sequence enter_seen;
        o_screen == SCR_STARTUP && i_keys[ENTER_KEY];
    endsequence
    // ==========================================================
    // checks
    chk_mode_held: assert property (captured && $past(captured) |->
        $stable(o_standard_mode) && $stable(o_demo_mode))
        else $error("mode changed after capture");
    chk_leds_all: assert property (o_leds != '0 |-> o_leds == '1)
        else $error("leds partly lit");
    chk_leds_first: assert property (o_self_test_start |->
        $past(o_leds, 2) == '1) else $error("self-test before led phase");
    chk_test_pulse: assert property (o_self_test_start |=>
        !o_self_test_start) else $error("self-test start too long");
    chk_sort_pulse: assert property (o_sort_start |-> ##1
        (!o_sort_start && o_screen == SCR_INIT_BUFFER))
        else $error("sort start pulse or indication wrong");
    chk_sort_startup: assert property (sort_seen |-> ##[1:2]
        o_screen == SCR_STARTUP) else $error("startup screen late");
    chk_hold_bound: assert property (hold_cnt <= HOLD_CYCLES + 4)
        else $error("startup screen held too long");
    chk_hold_full: assert property ($fell(o_screen == SCR_STARTUP) &&
        o_screen == SCR_MAIN |-> $past(hold_cnt) >= HOLD_CYCLES - 3)
        else $error("startup screen left early");
    chk_enter_setup: assert property (enter_seen |-> ##[1:3]
        o_screen == SCR_SETUP) else $error("enter did not open setup");
    chk_setup_stays: assert property (o_screen == SCR_SETUP |=>
        o_screen == SCR_SETUP) else $error("setup screen left");
    chk_error_sticky: assert property (o_key_test_error |=>
        o_key_test_error) else $error("key error cleared");
    chk_link_gate: assert property (o_link_enable |->
        !o_demo_mode && o_screen == SCR_MAIN) else $error("link enabled");
    chk_kbd_gate: assert property (o_keyboard_enable |->
        o_screen inside {SCR_MAIN, SCR_SETUP}) else $error("keyboard on");
    chk_std_quiet: assert property (o_standard_mode |-> !o_tx_valid)
        else $error("character sent in standard mode");
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_char)) else $error("offer dropped");
    chk_tx_code: assert property (o_tx_valid |-> o_tx_char inside
        {[8'h41:8'h41 + NUM_KEYS - 1], [8'h61:8'h61 + NUM_KEYS - 1]})
        else $error("bad key code");
endmodule : startup_properties

bind terminal_startup_mode_select startup_properties #(
    .NUM_KEYS(NUM_KEYS), .NUM_LEDS(NUM_LEDS), .ENTER_KEY(ENTER_KEY),
    .HOLD_CYCLES(HOLD_CYCLES)
) startup_properties_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_keys(i_keys),
    .i_sort_done(i_sort_done), .i_tx_ready(i_tx_ready), .o_leds(o_leds),
    .o_self_test_start(o_self_test_start), .o_sort_start(o_sort_start),
    .o_standard_mode(o_standard_mode), .o_demo_mode(o_demo_mode),
    .o_link_enable(o_link_enable), .o_keyboard_enable(o_keyboard_enable),
    .o_key_test_error(o_key_test_error), .o_screen(o_screen),
    .o_tx_valid(o_tx_valid), .o_tx_char(o_tx_char)
);

// >>> dv/testbench.sv
// self-checking bench for the terminal startup sequencer
`timescale 1ns/1ps
`include "startup_map.svh"
module testbench;
    import startup_pkg::*;
    localparam int HOLD = 100;
    logic mclk = 0, rst = 1, st_done = 0, st_fail = 0, desc = 0;
    logic sort_done = 0, slow = 0, tx_ready, tx_valid, st_start, sort_start;
    logic erase, std_mode, demo, link_en, kbd_en, key_err, st_err;
    logic [7:0] sw = 8'h00, tx_char;
    logic [15:0] keys = 16'h0000, leds;
    logic [7:0] exp_q[$];
    screen_type scr;
    int seed = 32'h9364, err_total = 0, compares = 0;
    terminal_startup_mode_select #(.HOLD_CYCLES(HOLD))
        terminal_startup_mode_select_i (
        .i_mclk(mclk), .i_rst(rst), .i_mode_switch(sw), .i_keys(keys),
        .i_self_test_done(st_done), .i_self_test_fail(st_fail),
        .i_description_valid(desc), .i_sort_done(sort_done),
        .i_tx_ready(tx_ready), .o_leds(leds), .o_self_test_start(st_start),
        .o_sort_start(sort_start), .o_flash_erase(erase),
        .o_standard_mode(std_mode), .o_demo_mode(demo),
        .o_link_enable(link_en), .o_keyboard_enable(kbd_en),
        .o_key_test_error(key_err), .o_self_test_error(st_err),
        .o_screen(scr), .o_tx_valid(tx_valid), .o_tx_char(tx_char));
    plc_link_model plc_link_model_i (.i_mclk(mclk), .i_rst(rst),
        .i_slow(slow), .i_tx_valid(tx_valid), .i_tx_char(tx_char),
        .o_tx_ready(tx_ready));
    // ==========================================================
    // clock and helpers
    initial forever #2.5 mclk = ~mclk;
    task automatic cmp_val(logic [15:0] got, logic [15:0] exp, string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_scr(screen_type got, screen_type exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: screen %0d want %0d", $time, got, exp);
        end
    endtask : cmp_scr
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wait_scr(screen_type s);
        int n;
        for (n = 0; n < 400 && scr !== s; n++) tick(1);
        cmp_scr(scr, s);
    endtask : wait_scr
    task automatic wait_hi(ref logic sig, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sig !== 1'b1 && n < 400);
    endtask : wait_hi
    function automatic logic [7:0] key_code(int k, logic press);
        return (press ? 8'h41 : 8'h61) + 8'(k);
    endfunction : key_code
    // ==========================================================
    // power-up sequence up to the startup screen
    task automatic power_up(logic s_std, s_demo, s_erase, held, valid);
        logic [7:0] v;
        int n;
        v = 8'($random(seed));
        v[`SW_MODE_SELECT_POSITION] = s_std;
        v[`SW_DEMO_SELECT_POSITION] = s_demo;
        v[`SW_FLASH_ERASE_POSITION] = s_erase;
        @(posedge mclk);
        rst <= 1'b1;
        sw <= v;
        desc <= valid;
        keys <= {15'h0000, held};
        st_fail <= s_erase;
        tick(5);
        cmp_val(leds, 16'hffff, "leds in reset");
        @(posedge mclk) rst <= 1'b0;
        tick(1);
        cmp_val(std_mode, s_std, "standard mode");
        cmp_val(demo, s_demo, "demo mode");
        cmp_val(erase, s_erase, "flash erase");
        cmp_val(leds, 16'hffff, "leds on");
        @(posedge mclk) sw <= ~v;
        wait_hi(st_start, n);
        cmp_val(n > 12 && n < 20, 1'b1, "led phase");
        tick(2);
        cmp_val(leds, 16'h0000, "leds off");
        cmp_val(std_mode, s_std, "mode kept");
        @(posedge mclk) st_done <= 1'b1;
        @(posedge mclk) st_done <= 1'b0;
        if (held) begin
            wait_scr(SCR_RELEASE_KEYS);
            cmp_val(key_err, 1'b1, "key error");
            @(posedge mclk) keys <= 16'h0000;
        end
        if (!valid) begin
            wait_scr(SCR_DOWNLOAD);
            cmp_val({link_en, kbd_en}, 2'b00, "gated");
            @(posedge mclk) desc <= 1'b1;
        end
        wait_hi(sort_start, n);
        cmp_scr(scr, SCR_INIT_BUFFER);
        // sorter answers no earlier than the edge after its start pulse
        repeat (1 + {$random(seed)} % 30) @(posedge mclk);
        sort_done <= 1'b1;
        @(posedge mclk) sort_done <= 1'b0;
        wait_scr(SCR_STARTUP);
        cmp_val(key_err, held, "key error kept");
        cmp_val(st_err, s_erase, "self-test error");
    endtask : power_up
    task automatic hold_main(logic s_demo);
        int n;
        for (n = 0; n < HOLD + 50 && scr === SCR_STARTUP; n++) tick(1);
        cmp_val(n > HOLD - 4 && n < HOLD + 6, 1'b1, "hold time");
        cmp_scr(scr, SCR_MAIN);
        tick(1);
        cmp_val({link_en, kbd_en}, {!s_demo, 1'b1}, "enables");
    endtask : hold_main
    task automatic enter_setup();
        @(posedge mclk) keys <= 16'h0001;
        wait_scr(SCR_SETUP);
        @(posedge mclk) keys <= 16'h0000;
        tick(HOLD + 10);
        cmp_scr(scr, SCR_SETUP);
        cmp_val(kbd_en, 1'b1, "keyboard");
    endtask : enter_setup
    // random key strokes, checked against the characters received
    task automatic key_run(logic transp);
        int k;
        plc_link_model_i.got.delete();
        exp_q.delete();
        repeat (6) begin
            k = {$random(seed)} % 16;
            @(posedge mclk) keys[k] <= 1'b1;
            tick(20);
            @(posedge mclk) keys[k] <= 1'b0;
            tick(20);
            if (transp) exp_q.push_back(key_code(k, 1'b1));
            if (transp) exp_q.push_back(key_code(k, 1'b0));
        end
        cmp_val(plc_link_model_i.got.size(), exp_q.size(), "chars");
        foreach (exp_q[i]) cmp_val(plc_link_model_i.got[i], exp_q[i], "c");
    endtask : key_run
    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // main sequence and watchdog
    initial begin
        power_up(1, 0, 1, 1, 1);
        enter_setup();
        key_run(0);
        slow <= 1'b1;
        power_up(0, 0, 0, 0, 0);
        hold_main(0);
        key_run(1);
        power_up(1, 1, 0, 0, 1);
        hold_main(1);
        key_run(0);
        slow <= 1'b0;
        power_up(0, 1, 1, 0, 1);
        hold_main(1);
        key_run(0);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        wrap_up();
    end
endmodule : testbench
